// ---- core/pcs_synth_ctrl.sv ----
// Clock synthesizer control: reference select, counters, lock, registers.
`timescale 1ns/100ps
`include "pcs_map.svh"
module pcs_synth_ctrl
#(
  parameter int SYNTH_INSTANCES = 8
)
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Reference clocks and control from the fabric
  input wire pcs_pkg::pcs_ref_vec_t i_ref_clock_inputs,
  input wire pcs_pkg::pcs_ref_vec_t i_ref_pad_n,
  input wire pcs_pkg::pcs_ref_vec_t i_ref_core_clocks,
  input wire pcs_pkg::pcs_ref_sel_t i_ref_clock_select,
  input wire logic i_synth_reset_low,
  input wire logic i_core_feedback_clock,
  // Synthesized clocks and status
  output logic o_synth_out_clock_0,
  output logic o_synth_out_clock_1,
  output logic o_synth_out_clock_2,
  output logic o_locked,
  output logic o_irq
);
  import pcs_pkg::*;

  localparam pcs_state_t ST_RST = '{
    cfg0: `PCS_CFG0_RST,
    cfg1: `PCS_CFG1_RST,
    ctrl: `PCS_CTRL_RST,
    rst_q: 1'b1,
    lstate: PCS_LK_IDLE,
    default: '0
  };

  pcs_state_t st_reg;
  pcs_state_t st_next;

  // ========================================================================
  // Decoded configuration
  logic [3:0] pre_div;
  logic [3:0] n_eff;
  logic [1:0] post_code;
  logic [3:0] post_val;
  logic [7:0] mult;
  logic [7:0] fb_div;
  logic [2:0][7:0] out_div;
  pcs_fb_mode_t fb_mode;
  logic [1:0] fb_sel;
  logic [2:0] out_en;
  logic [3:0] src_core;
  logic [3:0] diff_en;
  logic [19:0] prod;
  logic prod_ovf;
  logic [8:0] inc;
  logic bad_cfg;

  assign pre_div = st_reg.cfg0[`PCS_PRE_DIV_LSB +: 4];
  assign n_eff = (pre_div == 4'h0) ? 4'h1 : pre_div;
  assign post_code = st_reg.cfg0[`PCS_POST_DIV_LSB +: 2];
  assign post_val = 4'(4'h1 << post_code);
  assign mult = st_reg.cfg0[`PCS_MULT_LSB +: 8];
  assign fb_div = st_reg.cfg0[`PCS_FB_DIV_LSB +: 8];
  assign out_div = st_reg.cfg1[23:0];
  assign fb_mode = pcs_fb_mode_t'(st_reg.ctrl[`PCS_FB_MODE_LSB +: 2]);
  assign fb_sel = st_reg.ctrl[`PCS_FB_SEL_LSB +: 2];
  assign out_en = st_reg.ctrl[`PCS_OUT_EN_LSB +: 3];
  assign src_core = st_reg.ctrl[`PCS_SRC_CORE_LSB +: 4];
  assign diff_en = st_reg.ctrl[`PCS_DIFF_EN_LSB +: 4];

  // Local and core feedback put the post and feedback dividers inside the
  // loop, so the oscillator runs O*Cfb faster for the same comparison rate.
  assign prod = 20'(mult) * 20'(post_val) * 20'(fb_div);
  assign prod_ovf = prod > 20'(`PCS_PROD_MAX);
  // Two edge events per oscillator period.
  assign inc = (fb_mode == PCS_FB_LOCAL || fb_mode == PCS_FB_CORE)
             ? {prod[7:0], 1'b0}
             : {mult, 1'b0};
  assign bad_cfg = ((fb_mode == PCS_FB_LOCAL || fb_mode == PCS_FB_CORE)
                    && prod_ovf)
                 || (fb_mode == PCS_FB_CORE && fb_sel == 2'h3);

  // ========================================================================
  // Reference sources
  logic [3:0] ref_src;
  logic sel_ref;
  logic ref_rise;
  logic fb_rise;

  for (genvar i = 0; i < 4; i++)
  begin : g_ref
    assign ref_src[i] = src_core[i] ? i_ref_core_clocks[i]
                      : diff_en[i] ? (i_ref_clock_inputs[i] & ~i_ref_pad_n[i])
                      : i_ref_clock_inputs[i];
  end

  assign sel_ref = ref_src[i_ref_clock_select];
  assign ref_rise = sel_ref & ~st_reg.ref_q;
  assign fb_rise = i_core_feedback_clock & ~st_reg.fb_q;

  // ========================================================================
  // Register read decode
  logic [31:0] rd_word;

  always_comb
  begin
    case (i_wb_adr)
      `PCS_ADR_CFG0: rd_word = st_reg.cfg0;
      `PCS_ADR_CFG1: rd_word = st_reg.cfg1;
      `PCS_ADR_CTRL: rd_word = st_reg.ctrl;
      `PCS_ADR_STATUS: rd_word = {st_reg.per_val,
                                  4'(SYNTH_INSTANCES),
                                  6'h00, st_reg.lstate, st_reg.sel_q,
                                  st_reg.rst_q, st_reg.locked};
      `PCS_ADR_IRQ_STAT: rd_word = {27'h0, st_reg.irq_stat};
      `PCS_ADR_IRQ_EN: rd_word = {27'h0, st_reg.irq_en};
      default: rd_word = 32'h00000000;
    endcase
  end

  function automatic logic [31:0] wmerge(input logic [31:0] old_w,
                                         input logic [31:0] new_w,
                                         input logic [3:0] sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        res[b*8 +: 8] = new_w[b*8 +: 8];
    end
    return res;
  endfunction

  // ========================================================================
  // Next state
  logic wb_req;
  logic [4:0] irq_clr;
  logic [4:0] ev;
  logic pfd;
  logic close;
  logic fb_ok;
  logic [17:0] sum;
  logic [17:0] rem;

  assign wb_req = i_wb_cyc & i_wb_stb & ~st_reg.ack;

  always_comb
  begin
    st_next = st_reg;
    st_next.ack = 1'b0;
    st_next.vco_tick = 1'b0;
    irq_clr = 5'h00;
    ev = 5'h00;
    pfd = 1'b0;
    sum = 18'h00000;
    rem = 18'h00000;
    close = (st_reg.per_cnt == st_reg.per_val)
         || (st_reg.per_cnt == st_reg.per_val + 16'h0001)
         || (st_reg.per_cnt + 16'h0001 == st_reg.per_val);
    fb_ok = (fb_mode != PCS_FB_CORE) || st_reg.fb_seen || fb_rise;

    // Bus: the answer comes one cycle after the request is seen.
    if (wb_req)
    begin
      st_next.ack = 1'b1;
      st_next.rdata = rd_word;
      if (i_wb_we)
      begin
        case (i_wb_adr)
          `PCS_ADR_CFG0:
            st_next.cfg0 = wmerge(st_reg.cfg0, i_wb_dat, i_wb_sel)
                         & `PCS_CFG0_MASK;
          `PCS_ADR_CFG1:
            st_next.cfg1 = wmerge(st_reg.cfg1, i_wb_dat, i_wb_sel)
                         & `PCS_CFG1_MASK;
          `PCS_ADR_CTRL:
            st_next.ctrl = wmerge(st_reg.ctrl, i_wb_dat, i_wb_sel)
                         & `PCS_CTRL_MASK;
          `PCS_ADR_IRQ_EN:
            st_next.irq_en = 5'(wmerge({27'h0, st_reg.irq_en}, i_wb_dat,
                                       i_wb_sel));
          `PCS_ADR_IRQ_CLR:
            irq_clr = 5'(wmerge(32'h0, i_wb_dat, i_wb_sel));
          default:
          begin
          end
        endcase
      end
    end

    st_next.ref_q = sel_ref;
    st_next.sel_q = i_ref_clock_select;
    st_next.rst_q = i_synth_reset_low;
    st_next.fb_q = i_core_feedback_clock;

    if (!i_synth_reset_low)
    begin
      // Low level holds the whole loop in reset and drops lock.
      if (st_reg.rst_len != 4'hF)
        st_next.rst_len = st_reg.rst_len + 4'h1;
      st_next.lstate = PCS_LK_IDLE;
      st_next.pre_cnt = 4'h0;
      st_next.per_cnt = 16'h0000;
      st_next.per_val = 16'h0000;
      st_next.stable = 4'h0;
      st_next.acc = 17'h00000;
      st_next.fb_seen = 1'b0;
    end
    else
    begin
      if (!st_reg.rst_q)
      begin
        if (st_reg.rst_len < 4'(`PCS_RST_MIN_CYC))
          ev[`PCS_IRQ_SHORT] = 1'b1;
        st_next.rst_len = 4'h0;
      end
      if (st_reg.rst_q && i_ref_clock_select != st_reg.sel_q)
        ev[`PCS_IRQ_SEL] = 1'b1;
      if (bad_cfg)
        ev[`PCS_IRQ_OVF] = 1'b1;
      if (fb_rise)
        st_next.fb_seen = 1'b1;
      if (st_reg.per_cnt != `PCS_PER_MAX)
        st_next.per_cnt = st_reg.per_cnt + 16'h0001;

      // Pre-divider: one comparison event every N reference edges.
      if (ref_rise)
      begin
        if ({1'b0, st_reg.pre_cnt} + 5'h01 >= {1'b0, n_eff})
        begin
          st_next.pre_cnt = 4'h0;
          pfd = 1'b1;
        end
        else
        begin
          st_next.pre_cnt = st_reg.pre_cnt + 4'h1;
        end
      end

      // Lock detector: the comparison period must repeat within one cycle.
      if (pfd)
      begin
        // The event edge is the first cycle of the new period, so a
        // reference of P cycles is measured as P, not P-1.
        st_next.per_cnt = 16'h0001;
        st_next.fb_seen = 1'b0;
        if (st_reg.lstate == PCS_LK_IDLE)
        begin
          st_next.lstate = PCS_LK_ACQ;
          st_next.per_val = st_reg.per_cnt;
          st_next.stable = 4'h0;
        end
        else if (close && fb_ok && !bad_cfg)
        begin
          if (st_reg.stable == 4'(`PCS_LOCK_PERIODS - 1))
            st_next.lstate = PCS_LK_LOCKED;
          else
            st_next.stable = st_reg.stable + 4'h1;
        end
        else
        begin
          st_next.lstate = PCS_LK_ACQ;
          st_next.per_val = st_reg.per_cnt;
          st_next.stable = 4'h0;
        end
      end
      else if (st_reg.per_cnt == `PCS_PER_MAX)
      begin
        // Reference stopped: restart acquisition from scratch.
        st_next.lstate = PCS_LK_IDLE;
        st_next.per_val = 16'h0000;
        st_next.stable = 4'h0;
      end
      else if (bad_cfg && st_reg.lstate == PCS_LK_LOCKED)
      begin
        st_next.lstate = PCS_LK_ACQ;
        st_next.stable = 4'h0;
      end

      // Oscillator model: edges at inc/per_val of the system rate. It can
      // give at most one edge per cycle, so faster settings saturate.
      if (st_reg.lstate != PCS_LK_IDLE && st_reg.per_val != 16'h0000)
      begin
        sum = {1'b0, st_reg.acc} + 18'(inc);
        if (sum >= {2'b00, st_reg.per_val})
        begin
          rem = sum - {2'b00, st_reg.per_val};
          st_next.vco_tick = 1'b1;
          st_next.acc = (rem >= {2'b00, st_reg.per_val}) ? 17'h00000
                                                         : rem[16:0];
        end
        else
        begin
          st_next.acc = sum[16:0];
        end
      end
    end

    st_next.locked = (st_next.lstate == PCS_LK_LOCKED);
    if (!st_reg.locked && st_next.locked)
      ev[`PCS_IRQ_LOCK] = 1'b1;
    if (st_reg.locked && !st_next.locked && i_synth_reset_low)
      ev[`PCS_IRQ_LOSS] = 1'b1;
    // A new event beats a clear arriving in the same cycle.
    st_next.irq_stat = (st_reg.irq_stat & ~irq_clr) | ev;
    st_next.irq = |(st_next.irq_stat & st_next.irq_en);
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
      st_reg <= ST_RST;
    else
      st_reg <= st_next;
  end

  // ========================================================================
  // Post divider and three output dividers
  logic post_tick;
  logic [2:0] out_clk;

  pcs_tick_div u_post_div (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_en(st_reg.rst_q),
    .i_div({4'h0, post_val}),
    .i_tick(st_reg.vco_tick),
    .o_tick(post_tick),
    .o_clk()
  );

  for (genvar k = 0; k < 3; k++)
  begin : g_out
    pcs_tick_div u_out_div (
      .i_ref_clk(i_ref_clk),
      .i_rst_b(i_rst_b),
      .i_en(st_reg.rst_q & out_en[k]),
      .i_div(out_div[k]),
      .i_tick(post_tick),
      .o_tick(),
      .o_clk(out_clk[k])
    );
  end

  assign o_synth_out_clock_0 = out_clk[0];
  assign o_synth_out_clock_1 = out_clk[1];
  assign o_synth_out_clock_2 = out_clk[2];
  assign o_locked = st_reg.locked;
  assign o_irq = st_reg.irq;
  assign o_wb_ack = st_reg.ack;
  assign o_wb_dat = st_reg.rdata;

  // ========================================================================
  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_wb_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence

  sequence s_run_sel_change;
    i_synth_reset_low && st_reg.rst_q &&
      (i_ref_clock_select != st_reg.sel_q);
  endsequence

  a_wb_ack_next: assert property (s_wb_req |=> o_wb_ack ##1 !o_wb_ack)
    else $error("bus answer not a single cycle after request");
  a_lock_reset: assert property (!i_synth_reset_low |=> !o_locked)
    else $error("lock reported while held in reset");
  a_out_reset: assert property (!i_synth_reset_low |-> ##2
    (!o_synth_out_clock_0 && !o_synth_out_clock_1 && !o_synth_out_clock_2))
    else $error("output clock running in reset");
  a_lock_timeout: assert property (i_synth_reset_low &&
    st_reg.per_cnt == `PCS_PER_MAX && !ref_rise |=> !o_locked)
    else $error("lock kept with stopped reference");
  a_lock_flag: assert property ($rose(o_locked) |->
    st_reg.irq_stat[`PCS_IRQ_LOCK] && $past(st_reg.lstate == PCS_LK_ACQ))
    else $error("lock rose without acquisition or flag");
  a_sel_flag: assert property (s_run_sel_change |=>
    st_reg.irq_stat[`PCS_IRQ_SEL])
    else $error("reference change while running not flagged");
  a_prod_limit: assert property (i_synth_reset_low &&
    fb_mode != PCS_FB_INTERNAL && fb_mode != PCS_FB_RSVD && prod_ovf
    |=> !o_locked)
    else $error("lock with loop product above limit");
  a_core_fb_sel: assert property (fb_mode == PCS_FB_CORE &&
    fb_sel == 2'h3 |=> !o_locked)
    else $error("core feedback with invalid output selection locked");
  a_short_reset: assert property ($rose(i_synth_reset_low) &&
    st_reg.rst_len < 4'(`PCS_RST_MIN_CYC) |=>
    st_reg.irq_stat[`PCS_IRQ_SHORT])
    else $error("short reset pulse not flagged");
  a_irq_level: assert property (st_reg.irq_stat[`PCS_IRQ_LOSS] &&
    st_reg.irq_en[`PCS_IRQ_LOSS] |-> o_irq)
    else $error("enabled status bit without interrupt");

endmodule

// ---- shared/pcs_map.svh ----
// Register offsets, field positions, reset values and timing counts.
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH

// ==========================================================================
// Register byte offsets
`define PCS_ADR_CFG0 8'h00
`define PCS_ADR_CFG1 8'h04
`define PCS_ADR_CTRL 8'h08
`define PCS_ADR_STATUS 8'h0C
`define PCS_ADR_IRQ_STAT 8'h10
`define PCS_ADR_IRQ_EN 8'h14
`define PCS_ADR_IRQ_CLR 8'h18

// ==========================================================================
// Reset values and writable masks
`define PCS_CFG0_RST 32'h00010101
`define PCS_CFG0_MASK 32'h00FFFF3F
`define PCS_CFG1_RST 32'h00010101
`define PCS_CFG1_MASK 32'h00FFFFFF
`define PCS_CTRL_RST 32'h00000070
`define PCS_CTRL_MASK 32'h0000FF7F

// ==========================================================================
// Field positions
`define PCS_PRE_DIV_LSB 0
`define PCS_POST_DIV_LSB 4
`define PCS_MULT_LSB 8
`define PCS_FB_DIV_LSB 16
`define PCS_FB_MODE_LSB 0
`define PCS_FB_SEL_LSB 2
`define PCS_OUT_EN_LSB 4
`define PCS_SRC_CORE_LSB 8
`define PCS_DIFF_EN_LSB 12

// ==========================================================================
// Interrupt bits
`define PCS_IRQ_W 5
`define PCS_IRQ_LOCK 0
`define PCS_IRQ_LOSS 1
`define PCS_IRQ_SEL 2
`define PCS_IRQ_OVF 3
`define PCS_IRQ_SHORT 4

// ==========================================================================
// Timing
`define PCS_CLK_PERIOD_NS 5
`define PCS_RST_MIN_NS 10
`define PCS_RST_MIN_CYC ((`PCS_RST_MIN_NS + `PCS_CLK_PERIOD_NS - 1) / `PCS_CLK_PERIOD_NS)
`define PCS_LOCK_PERIODS 8
`define PCS_PER_MAX 16'hFFFF
`define PCS_PROD_MAX 255

`endif

// ---- shared/pcs_pkg.sv ----
// Types shared by the clock synthesizer control block.
package pcs_pkg;

  typedef logic [3:0] pcs_ref_vec_t;
  typedef logic [1:0] pcs_ref_sel_t;

  typedef enum logic [1:0] {
    PCS_FB_INTERNAL,
    PCS_FB_LOCAL,
    PCS_FB_CORE,
    PCS_FB_RSVD
  } pcs_fb_mode_t;

  typedef enum logic [1:0] {
    PCS_LK_IDLE,
    PCS_LK_ACQ,
    PCS_LK_LOCKED
  } pcs_lock_state_t;

  typedef struct packed {
    logic [31:0] cfg0;
    logic [31:0] cfg1;
    logic [31:0] ctrl;
    logic [4:0] irq_stat;
    logic [4:0] irq_en;
    logic irq;
    logic ack;
    logic [31:0] rdata;
    logic ref_q;
    logic [1:0] sel_q;
    logic rst_q;
    logic [3:0] rst_len;
    logic [3:0] pre_cnt;
    logic [15:0] per_cnt;
    logic [15:0] per_val;
    logic [3:0] stable;
    pcs_lock_state_t lstate;
    logic locked;
    logic [16:0] acc;
    logic vco_tick;
    logic fb_q;
    logic fb_seen;
  } pcs_state_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
    logic clk;
  } pcs_div_state_t;

endpackage

// ---- core/pcs_tick_div.sv ----
// Edge-event divider that also toggles a clock output.
`timescale 1ns/100ps
module pcs_tick_div
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Control
  input wire logic i_en,
  input wire logic [7:0] i_div,
  // Events
  input wire logic i_tick,
  output logic o_tick,
  output logic o_clk
);
  import pcs_pkg::*;

  pcs_div_state_t st_reg;
  pcs_div_state_t st_next;
  logic [7:0] div_eff;

  // A zero divide value acts as one so the chain never stalls.
  assign div_eff = (i_div == 8'h00) ? 8'h01 : i_div;

  always_comb
  begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (!i_en)
    begin
      st_next = '0;
    end
    else if (i_tick)
    begin
      if ({1'b0, st_reg.cnt} + 9'h001 >= {1'b0, div_eff})
      begin
        st_next.cnt = 8'h00;
        st_next.tick = 1'b1;
        st_next.clk = ~st_reg.clk;
      end
      else
      begin
        st_next.cnt = st_reg.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign o_tick = st_reg.tick;
  assign o_clk = st_reg.clk;

  // ========================================================================
  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  a_div_tick: assert property (i_en && i_tick &&
    ({1'b0, st_reg.cnt} + 9'h001 >= {1'b0, div_eff}) |=> o_tick)
    else $error("divider missed its terminal count");
  a_div_quiet: assert property (!i_en |=> !o_clk && !o_tick)
    else $error("disabled divider still drives its clock");

endmodule

// ---- testbench/pcs_fabric_model.sv ----
// Far-side model: fabric reference clocks and core feedback loop.
`timescale 1ns/100ps
module pcs_fabric_model
(
  // Clock and pace
  input wire logic i_ref_clk,
  input wire logic [7:0] i_half,
  input wire logic i_out_clk,
  // Toward the synthesizer
  output logic [3:0] o_ref,
  output logic [3:0] o_ref_n,
  output logic [3:0] o_core,
  output logic o_fb
);
  logic [7:0] cnt_reg;
  logic ph_reg;
  initial
  begin
    cnt_reg = 8'h00;
    ph_reg = 1'b0;
  end
  // One shared period, so a select change keeps the reference rate.
  always @(posedge i_ref_clk)
  begin
    if (cnt_reg + 8'h01 >= i_half)
    begin
      cnt_reg <= 8'h00;
      ph_reg <= ~ph_reg;
    end
    else
      cnt_reg <= cnt_reg + 8'h01;
  end
  assign o_ref = {4{ph_reg}};
  assign o_ref_n = {4{~ph_reg}};
  assign o_core = {4{ph_reg}};
  assign o_fb = i_out_clk;
endmodule

// ---- testbench/test_pcs_synth_ctrl.sv ----
// Self-checking bench for the clock synthesizer control block.
`timescale 1ns/100ps
module test_pcs_synth_ctrl;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'hF;
  logic [31:0] rdat;
  logic ack, o0, o1, o2, locked, irq, fb;
  logic [1:0] rsel = 2'h0;
  logic srst_b = 1'b0;
  logic [3:0] rp, rn, rc;
  int n_fail = 0;
  int cmp_count = 0;
  always #2.5 clk = ~clk;
  pcs_fabric_model fab_u (.i_ref_clk(clk), .i_half(8'h14), .i_out_clk(o0),
    .o_ref(rp), .o_ref_n(rn), .o_core(rc), .o_fb(fb));
  pcs_synth_ctrl dut_u (.i_ref_clk(clk), .i_rst_b(rst_b), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat),
    .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_ref_clock_inputs(rp), .i_ref_pad_n(rn), .i_ref_core_clocks(rc),
    .i_ref_clock_select(rsel), .i_synth_reset_low(srst_b),
    .i_core_feedback_clock(fb), .o_synth_out_clock_0(o0),
    .o_synth_out_clock_1(o1), .o_synth_out_clock_2(o2),
    .o_locked(locked), .o_irq(irq));
  // ==========================================================
  // Bus and compare helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    @(posedge clk);
    while (ack !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    q = rdat;
    if (n >= 50)
      chk(32'h1, 32'h0);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic wait_lock(input logic e);
    int n;
    n = 0;
    while (locked !== e && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rdc(8'h00, 32'h00010101);
    rdc(8'h04, 32'h00010101);
    rdc(8'h08, 32'h00000070);
    rdc(8'h14, 32'h00000000);
    rdc(8'h18, 32'h00000000);
    rdc(8'h40, 32'h00000000);
    rdc(8'h0C, 32'h00008000);
    wr(8'h00, 32'hFFFFFFFF);
    rdc(8'h00, 32'h00FFFF3F);
    wr(8'h14, 32'h0000001F);
    rdc(8'h14, 32'h0000001F);
    wr(8'h10, 32'h0000001F);
    rdc(8'h10, 32'h00000000);
    $display("test regs done");
  endtask
  task automatic t_lock;
    int c0, c1, c2;
    logic p0, p1, p2;
    c0 = 0;
    c1 = 0;
    c2 = 0;
    wr(8'h00, 32'h00010401);
    wr(8'h04, 32'h00010201);
    wr(8'h14, 32'h00000001);
    srst_b <= 1'b1;
    wait_lock(1'b1);
    chk(locked, 1'b1);
    @(posedge clk);
    chk(irq, 1'b1);
    rdc(8'h10, 32'h00000001);
    rdc(8'h0C, 32'h00288023);
    wr(8'h18, 32'h00000001);
    @(posedge clk);
    chk(irq, 1'b0);
    // Ref period 40 cycles, M=4: out0 and out2 toggle every 5 cycles,
    // out1 every 10. Outputs are only trusted once lock is reported.
    p0 = o0;
    p1 = o1;
    p2 = o2;
    repeat (400)
    begin
      @(posedge clk);
      if (o0 !== p0)
        c0++;
      if (o1 !== p1)
        c1++;
      if (o2 !== p2)
        c2++;
      p0 = o0;
      p1 = o1;
      p2 = o2;
    end
    chk(c0, 32'd80);
    chk(c1, 32'd40);
    chk(c2, 32'd80);
    $display("test lock done");
  endtask
  task automatic t_events;
    // A select change while running is flagged.
    rsel <= 2'h1;
    @(posedge clk);
    rdc(8'h10, 32'h00000004);
    wr(8'h18, 32'h0000001F);
    // A one-cycle reset pulse is too short: flagged, lock dropped.
    srst_b <= 1'b0;
    @(posedge clk);
    srst_b <= 1'b1;
    @(posedge clk);
    chk(locked, 1'b0);
    @(posedge clk);
    chk({o0, o1, o2}, 32'h0);
    rdc(8'h10, 32'h00000010);
    // Legal change: reset held low around the new selection.
    wr(8'h18, 32'h0000001F);
    srst_b <= 1'b0;
    @(posedge clk);
    rsel <= 2'h2;
    repeat (3) @(posedge clk);
    srst_b <= 1'b1;
    wait_lock(1'b1);
    chk(locked, 1'b1);
    rdc(8'h10, 32'h00000001);
    // Local feedback with M*O*Cfb = 256 must not hold lock.
    wr(8'h18, 32'h0000001F);
    wr(8'h08, 32'h00000071);
    wr(8'h00, 32'h00014021);
    repeat (100) @(posedge clk);
    chk(locked, 1'b0);
    rdc(8'h10, 32'h0000000A);
    // Core feedback from output 0 locks; output select 3 cannot.
    wr(8'h00, 32'h00010401);
    wr(8'h08, 32'h00000072);
    wait_lock(1'b1);
    chk(locked, 1'b1);
    wr(8'h08, 32'h0000007E);
    repeat (50) @(posedge clk);
    chk(locked, 1'b0);
    $display("test events done");
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_regs;
    t_lock;
    t_events;
    wrap_up;
  end
  // The tests need about 2000 cycles; a wide margin keeps slow locks legal.
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up;
  end
endmodule
